// >>> verilog/rspsp_defines.vh
`ifndef RSPSP_DEFINES_VH
`define RSPSP_DEFINES_VH
// ***************************************************************
// Register map
// ***************************************************************
`define RSPSP_ADDR_W          12
`define RSPSP_SYS_CTRL_OFF    12'h080
`define RSPSP_PWR_WORD_OFF    12'h084
`define RSPSP_STATUS_OFF      12'h088
`define RSPSP_SYS_CTRL_RST    32'h00000000
`define RSPSP_PWR_WORD_RST    32'h00000000
// ***************************************************************
// Field positions
// ***************************************************************
`define RSPSP_CLK_DIR_BIT     27
`define RSPSP_SUSPEND_BIT     0
`define RSPSP_BUSY_BIT        0
`define RSPSP_SW_CLK_IN_BIT   1
// ***************************************************************
// Timing
// ***************************************************************
`define RSPSP_WORD_BITS       16
`define RSPSP_CLK_DIV         4
`endif

// >>> verilog/rspsp_shifter.v
`timescale 1ns/10ps
`include "rspsp_defines.vh"
// ***************************************************************
// Serial shifter toward the power switch
// ***************************************************************
module rspsp_shifter #(
   parameter WORD_BITS = `RSPSP_WORD_BITS,
   parameter CLK_DIV   = `RSPSP_CLK_DIV
) (
   input  wire                 pclk,
   input  wire                 rst_n,
   input  wire                 start,
   input  wire [WORD_BITS-1:0] word,
   input  wire                 drive_clk,
   input  wire                 ext_clk_s,
   output reg                  sw_data,
   output reg                  sw_latch,
   output reg                  sw_clk_out,
   output wire                 busy
);
   localparam S_IDLE  = 2'd0;
   localparam S_SHIFT = 2'd1;
   localparam S_LATCH = 2'd2;

   reg [1:0]           state;
   reg [WORD_BITS-1:0] shreg;
   reg [7:0]           bitcnt;
   reg [7:0]           div;
   reg                 ext_q;
   wire                int_rise;
   wire                int_fall;
   wire                ext_rise;
   wire                ext_fall;
   wire                rise;
   wire                fall;

   assign int_rise = drive_clk && (div == CLK_DIV - 1) && !sw_clk_out;
   assign int_fall = drive_clk && (div == CLK_DIV - 1) && sw_clk_out;
   assign ext_rise = !drive_clk && ext_clk_s && !ext_q;
   assign ext_fall = !drive_clk && !ext_clk_s && ext_q;
   assign rise     = int_rise || ext_rise;
   assign fall     = int_fall || ext_fall;
   assign busy     = (state != S_IDLE);

   always @(posedge pclk or negedge rst_n) begin
      if (!rst_n) begin
         state      <= S_IDLE;
         shreg      <= {WORD_BITS{1'b0}};
         bitcnt     <= 8'h00;
         div        <= 8'h00;
         ext_q      <= 1'b0;
         sw_data    <= 1'b0;
         sw_latch   <= 1'b0;
         sw_clk_out <= 1'b0;
      end else begin
         ext_q <= ext_clk_s;
         if (div == CLK_DIV - 1) begin
            div <= 8'h00;
         end else begin
            div <= div + 8'h01;
         end
         if (int_rise || int_fall) begin
            sw_clk_out <= int_rise && busy;
         end
         case (state)
            S_IDLE: begin
               sw_latch <= 1'b0;
               if (start) begin
                  shreg   <= word;
                  sw_data <= word[WORD_BITS-1];
                  bitcnt  <= 8'h00;
                  state   <= S_SHIFT;
               end
            end
            S_SHIFT: begin
               // Data changes on the falling edge so it is stable at the rise
               if (rise) begin
                  bitcnt <= bitcnt + 8'h01;
               end
               if (fall && bitcnt != 8'h00) begin
                  if (bitcnt == WORD_BITS) begin
                     state    <= S_LATCH;
                     sw_latch <= 1'b1;
                  end else begin
                     shreg   <= {shreg[WORD_BITS-2:0], 1'b0};
                     sw_data <= shreg[WORD_BITS-2];
                  end
               end
            end
            S_LATCH: begin
               // Latch held for one switch clock period, no shifting meanwhile
               if (fall) begin
                  sw_latch <= 1'b0;
                  state    <= S_IDLE;
               end
            end
            default: begin
               state <= S_IDLE;
            end
         endcase
      end
   end
endmodule

// >>> verilog/rspsp_top.v
`timescale 1ns/10ps
`include "rspsp_defines.vh"
// Summary of operation
// - Whole-chip reset tri-states outputs, clears registers
// - Host bus reset tri-states, partial clear, blocks new words
// - Suspend keeps registers through whole-chip reset
// - Suspend keeps registers through host bus reset
// - Bus signals sampled on host clock rise
// - Switch samples data on clock rise
// - Switch clock input unless bit 27 set
// - Power word sent serially on data line
// - Latch marks shifted data valid
module rspsp_top #(
   parameter WORD_BITS = `RSPSP_WORD_BITS,
   parameter CLK_DIV   = `RSPSP_CLK_DIV
) (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        whole_chip_reset_n,
   input  wire        host_bus_reset_n,
   input  wire        suspend_n,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   input  wire        sw_clk_in,
   output wire        sw_clk_out,
   output wire        sw_clk_oe,
   output wire        sw_data,
   output wire        sw_data_oe,
   output wire        sw_latch,
   output wire        sw_latch_oe
);
   // ***************************************************************
   // Decode helpers
   // ***************************************************************
   // Used by the error response only; the read path decodes with its own case
   function is_mapped;
      input [11:0] addr;
      begin
         is_mapped = (addr == `RSPSP_SYS_CTRL_OFF) ||
                     (addr == `RSPSP_PWR_WORD_OFF) ||
                     (addr == `RSPSP_STATUS_OFF);
      end
   endfunction

   function [31:0] status_word;
      input busy_f;
      input clk_f;
      begin
         status_word                       = 32'h00000000;
         status_word[`RSPSP_BUSY_BIT]      = busy_f;
         status_word[`RSPSP_SW_CLK_IN_BIT] = clk_f;
      end
   endfunction

   // ***************************************************************
   // Synchronisers
   // ***************************************************************
   // Raw pins are flopped first; reset loads their idle levels
   localparam             N_SYNC    = 4;
   localparam [N_SYNC-1:0] SYNC_IDLE = 4'he;

   wire [N_SYNC-1:0] pin_raw;
   wire [N_SYNC-1:0] pin_s;
   wire              gr_act;
   wire              hr_act;
   wire              susp;
   wire              sw_clk_s;

   assign pin_raw = {whole_chip_reset_n, host_bus_reset_n, suspend_n, sw_clk_in};

   genvar g;
   generate
      for (g = 0; g < N_SYNC; g = g + 1) begin : g_sync
         reg s1;
         reg s2;

         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               s1 <= SYNC_IDLE[g];
               s2 <= SYNC_IDLE[g];
            end else begin
               s1 <= pin_raw[g];
               s2 <= s1;
            end
         end
         assign pin_s[g] = s2;
      end
   endgenerate

   assign gr_act   = !pin_s[3];
   assign hr_act   = !pin_s[2];
   assign susp     = !pin_s[1];
   assign sw_clk_s = pin_s[0];

   // ***************************************************************
   // Reset handling
   // ***************************************************************
   wire any_rst;
   wire clr_all;
   wire clr_some;

   // Suspend shields register contents, never the pins
   assign any_rst  = gr_act || hr_act;
   assign clr_all  = gr_act && !susp;
   assign clr_some = (gr_act || hr_act) && !susp;

   // ***************************************************************
   // Registers
   // ***************************************************************
   reg  [31:0] sys_ctrl;
   reg  [31:0] pwr_word;
   reg         start;
   wire        busy;
   wire        wr_acc;
   wire        wr_ctrl;
   wire        wr_word;
   wire        take_word;
   wire        rd_setup;
   wire        clk_dir;

   // Zero wait states: every access completes in its first access cycle
   assign wr_acc    = psel && penable && pwrite && !any_rst;
   assign wr_ctrl   = wr_acc && (paddr == `RSPSP_SYS_CTRL_OFF);
   assign wr_word   = wr_acc && (paddr == `RSPSP_PWR_WORD_OFF);
   // A write while busy is refused so a word is never torn
   assign take_word = wr_word && !busy && !start;
   assign rd_setup  = psel && !penable && !pwrite;
   assign clk_dir   = sys_ctrl[`RSPSP_CLK_DIR_BIT];
   assign pready    = 1'b1;
   assign pslverr   = psel && penable && !is_mapped(paddr);

   // Control survives a host bus reset; only the whole-chip one clears it
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sys_ctrl <= `RSPSP_SYS_CTRL_RST;
      end else if (clr_all) begin
         sys_ctrl <= `RSPSP_SYS_CTRL_RST;
      end else if (wr_ctrl) begin
         sys_ctrl <= pwdata;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pwr_word <= `RSPSP_PWR_WORD_RST;
         start    <= 1'b0;
      end else if (clr_some) begin
         pwr_word <= `RSPSP_PWR_WORD_RST;
         start    <= 1'b0;
      end else begin
         start <= take_word;
         if (take_word) begin
            pwr_word <= pwdata;
         end
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (rd_setup) begin
         // Loaded in setup, it stands through the access cycle
         case (paddr)
            `RSPSP_SYS_CTRL_OFF: prdata <= sys_ctrl;
            `RSPSP_PWR_WORD_OFF: prdata <= pwr_word;
            `RSPSP_STATUS_OFF:   prdata <= status_word(busy || start, sw_clk_s);
            default:             prdata <= 32'h00000000;
         endcase
      end
   end

   // ***************************************************************
   // Serial port
   // ***************************************************************
   wire sh_data;
   wire sh_latch;
   wire sh_clk;
   wire sh_rst_n;

   // Pin resets do not cut a word in flight, they only stop new ones and
   // release the pins; a cut word would leave the switch half loaded
   assign sh_rst_n = presetn;

   rspsp_shifter #(
      .WORD_BITS (WORD_BITS),
      .CLK_DIV   (CLK_DIV)
   ) rspsp_shifter_i (
      .pclk       (pclk),
      .rst_n      (sh_rst_n),
      .start      (start && !any_rst),
      .word       (pwr_word[WORD_BITS-1:0]),
      .drive_clk  (clk_dir),
      .ext_clk_s  (sw_clk_s),
      .sw_data    (sh_data),
      .sw_latch   (sh_latch),
      .sw_clk_out (sh_clk),
      .busy       (busy)
   );

   assign sw_data     = sh_data;
   assign sw_latch    = sh_latch;
   assign sw_clk_out  = sh_clk;

   // ***************************************************************
   // Output enables
   // ***************************************************************
   // Either reset releases every driven pin, suspended or not
   wire drive_ok;

   assign drive_ok    = !any_rst;
   assign sw_data_oe  = drive_ok;
   assign sw_latch_oe = drive_ok;
   assign sw_clk_oe   = clk_dir && drive_ok;
endmodule

// >>> dv/rspsp_monitor.sv
`timescale 1ns/10ps
// ****
// Port checker
// ****
module rspsp_monitor #(
   parameter WORD_BITS = 16
) (
   input logic        pclk,
   input logic        presetn,
   input logic        whole_chip_reset_n,
   input logic        host_bus_reset_n,
   input logic        psel,
   input logic        penable,
   input logic [11:0] paddr,
   input logic        pready,
   input logic        pslverr,
   input logic        sw_clk_in,
   input logic        sw_clk_out,
   input logic        sw_clk_oe,
   input logic        sw_data,
   input logic        sw_data_oe,
   input logic        sw_latch,
   input logic        sw_latch_oe
);
   logic [5:0] rises;
   wire        ck = sw_clk_oe ? sw_clk_out : sw_clk_in;
   // Saturates, so an idle clock between words cannot wrap it
   always @(posedge pclk or negedge presetn)
      if (!presetn) rises <= 6'h00;
      else if (sw_latch) rises <= 6'h00;
      else if ($rose(ck) && rises != 6'h3f) rises <= rises + 6'h01;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Pins pass a synchroniser, so allow it to settle
   sequence wc_held; !whole_chip_reset_n [*4]; endsequence
   sequence hb_held; !host_bus_reset_n [*4]; endsequence
   chip_rst_tri_a: assert property (wc_held |-> !sw_data_oe && !sw_latch_oe)
      else $error("driven in chip reset");
   bus_rst_tri_a: assert property (hb_held |-> !sw_data_oe && !sw_latch_oe)
      else $error("driven in bus reset");
   rst_clk_tri_a: assert property ((wc_held or hb_held) |-> !sw_clk_oe)
      else $error("clock driven in reset");
   pready_on_a: assert property (psel && penable |-> pready)
      else $error("access stalled");
   map_err_a: assert property (psel && penable |->
      pslverr == !(paddr inside {12'h080, 12'h084, 12'h088}))
      else $error("bad error response");
   data_rise_a: assert property (sw_clk_oe && $rose(sw_clk_out) |-> $stable(sw_data))
      else $error("data moved at rise");
   latch_count_a: assert property ($rose(sw_latch) |-> rises >= WORD_BITS)
      else $error("early latch");
   latch_drive_a: assert property ($rose(sw_latch) |-> sw_latch_oe)
      else $error("latch not driven");
endmodule
bind rspsp_top rspsp_monitor #(.WORD_BITS(WORD_BITS)) rspsp_monitor_i (.*);

// >>> dv/rspsp_switch.sv
`timescale 1ns/10ps
// ****
// Power switch model
// ****
module rspsp_switch (
   input  logic        run,
   input  logic        ck,
   input  logic        data,
   input  logic        latch,
   output logic        clk_ext,
   output logic [15:0] word
);
   logic [15:0] sr;
   // Parks low outside frames; offset keeps it off the bus clock phase
   initial begin
      clk_ext = 1'b0;
      #3;
      forever #40 clk_ext = run & ~clk_ext;
   end
   always @(posedge ck) sr <= {sr[14:0], data};
   always @(posedge latch) word <= sr;
endmodule

// >>> dv/tb.sv
`timescale 1ns/10ps
// ****
// Bench
// ****
module tb;
   logic        pclk, presetn, whole_chip_reset_n, host_bus_reset_n, suspend_n, psel;
   logic        penable, pwrite, pready, pslverr, sw_clk_in, sw_clk_out, sw_clk_oe, sw_data;
   logic        sw_data_oe, sw_latch, sw_latch_oe, run, clk_ext, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] word;
   int          n_fail = 0, n_checks = 0, cyc = 0;
   assign sw_clk_in = sw_clk_oe ? sw_clk_out : clk_ext;
   rspsp_top rspsp_top_i (.*);
   rspsp_switch rspsp_switch_i (.run, .ck(sw_clk_in), .data(sw_data), .latch(sw_latch),
      .clk_ext, .word);
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         report_and_stop;
      end
   end
   task report_and_stop;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: %h not %h", $time, got, exp);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      {psel, penable} <= 2'h0;
   endtask
   task idle;
      for (int i = 0; i < 300; i++) begin
         apb(1'b0, 12'h088, 32'h0);
         if (rd[0] === 1'b0) break;
      end
      repeat (30) @(posedge pclk);
   endtask
   // A write inside reset must be dropped
   task pin_rst(input logic [1:0] rst);
      {whole_chip_reset_n, host_bus_reset_n} <= ~rst;
      repeat (6) @(posedge pclk);
      chk({sw_data_oe, sw_latch_oe, sw_clk_oe}, 32'h0);
      apb(1'b1, 12'h084, 32'h1234);
      {whole_chip_reset_n, host_bus_reset_n} <= 2'h3;
      repeat (5) @(posedge pclk);
   endtask
   task t_regs;
      apb(1'b0, 12'h080, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 12'h0fc, 32'h0);
      chk(err, 32'h1);
   endtask
   task t_shift(input logic intc, input logic [15:0] w);
      apb(1'b1, 12'h080, {4'h0, intc, 27'h0});
      run <= ~intc;
      apb(1'b1, 12'h084, {16'h0, w});
      repeat (4) @(posedge pclk);
      apb(1'b0, 12'h088, 32'h0);
      chk(rd[0], 32'h1);
      idle;
      run <= 1'b0;
      chk(word, w);
      chk(sw_clk_oe, intc);
   endtask
   task t_resets;
      apb(1'b1, 12'h080, 32'h0800_0000);
      pin_rst(2'h1);
      apb(1'b0, 12'h080, 32'h0);
      chk(rd[27], 32'h1);
      apb(1'b0, 12'h084, 32'h0);
      chk(rd, 32'h0);
      pin_rst(2'h2);
      apb(1'b0, 12'h080, 32'h0);
      chk(rd, 32'h0);
      suspend_n <= 1'b0;
      apb(1'b1, 12'h080, 32'h0800_0000);
      apb(1'b1, 12'h084, 32'h00ff);
      idle;
      pin_rst(2'h2);
      apb(1'b0, 12'h080, 32'h0);
      chk(rd[27], 32'h1);
      pin_rst(2'h1);
      apb(1'b0, 12'h084, 32'h0);
      chk(rd, 32'h00ff);
      suspend_n <= 1'b1;
      apb(1'b1, 12'h080, 32'h0800_0000);
      pin_rst(2'h3);
      apb(1'b0, 12'h080, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 12'h084, 32'h0);
      chk(rd, 32'h0);
   endtask
   initial begin
      presetn = 1'b0;
      {whole_chip_reset_n, host_bus_reset_n, suspend_n} = 3'h7;
      {psel, penable, pwrite, paddr, pwdata, run} = '0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      t_regs;
      t_shift(1'b0, 16'ha5c3);
      t_shift(1'b1, 16'h3c81);
      t_resets;
      report_and_stop;
   end
endmodule
